// file: hw/mmu_pkg.sv
package mmu_pkg;
    // Internal I/O offsets of the translation registers
    localparam logic [7:0] COMMON_AREA_ONE_BASE_OFS = 8'h38;
    localparam logic [7:0] BANK_AREA_BASE_OFS = 8'h39;
    localparam logic [7:0] AREA_BOUNDARIES_OFS = 8'h3A;
    // Reset values
    localparam logic [7:0] COMMON_AREA_ONE_BASE_RST = 8'h00;
    localparam logic [7:0] BANK_AREA_BASE_RST = 8'h00;
    localparam logic [3:0] COMMON_ONE_START_RST = 4'hF;
    localparam logic [3:0] BANK_START_RST = 4'hF;
    // Field positions within the boundary register
    localparam int COMMON_ONE_START_LSB = 4;
    localparam int BANK_START_LSB = 0;
    // Address widths and page size
    localparam int LOG_AW = 16;
    localparam int PHY_AW = 20;
    localparam int PAGE_SHIFT = 12;
    // Area selection codes, one-hot
    typedef enum logic [2:0] {
        AREA_COMMON0 = 3'b001,
        AREA_BANK = 3'b010,
        AREA_COMMON1 = 3'b100
    } area_t;
endpackage

// file: hw/mmu_xlate.sv
`timescale 1ns/1ps
// Combinational area decode and physical address sum
module mmu_xlate (
    input wire logic [mmu_pkg::LOG_AW-1:0] log_addr,
    input wire logic [7:0] common_one_base,
    input wire logic [7:0] bank_base,
    input wire logic [3:0] common_one_start,
    input wire logic [3:0] bank_start,
    output logic [mmu_pkg::PHY_AW-1:0] phy_addr,
    output mmu_pkg::area_t area
);
    import mmu_pkg::*;

    logic [3:0] page;
    logic [7:0] base;

    // Common area 1 is checked first so that it wins on overlap
    always_comb begin
        page = log_addr[LOG_AW-1:PAGE_SHIFT];
        if (page >= common_one_start) begin
            area = AREA_COMMON1;
            base = common_one_base;
        end else if (page >= bank_start) begin
            area = AREA_BANK;
            base = bank_base;
        end else begin
            area = AREA_COMMON0;
            base = 8'h00;
        end
    end

    // Base page added above the in-page offset; carry out drops off
    always_comb begin
        phy_addr = {base, {PAGE_SHIFT{1'b0}}}
            + {{(PHY_AW-LOG_AW){1'b0}}, log_addr};
    end
endmodule // mmu_xlate

// file: hw/mmu_address_translation.sv
`timescale 1ns/1ps
module mmu_address_translation (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [mmu_pkg::LOG_AW-1:0] LOG_ADDR,
    input wire logic [7:0] IO_ADDR,
    input wire logic [7:0] IO_WDATA,
    input wire logic IO_WR,
    input wire logic IO_RD,
    output logic [7:0] IO_RDATA,
    output logic IO_HIT,
    output logic [mmu_pkg::PHY_AW-1:0] PHY_ADDR,
    output logic [2:0] AREA
);
    import mmu_pkg::*;

    logic [7:0] common_area_one_base_r;
    logic [7:0] bank_area_base_r;
    logic [3:0] common_one_start_field_r;
    logic [3:0] bank_start_field_r;
    area_t area_sel;
    logic [3:0] log_page;
    logic wr_common1;
    logic wr_bank;
    logic wr_bounds;

    // Offset match, shared by the write enables and the hit flag
    function automatic logic offset_is(input logic [7:0] addr,
            input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    // Write enables; only a mapped offset may alter a register
    always_comb begin
        wr_common1 = IO_WR && offset_is(IO_ADDR, COMMON_AREA_ONE_BASE_OFS);
        wr_bank = IO_WR && offset_is(IO_ADDR, BANK_AREA_BASE_OFS);
        wr_bounds = IO_WR && offset_is(IO_ADDR, AREA_BOUNDARIES_OFS);
    end

    // Page number of the current access, for the area checks
    always_comb begin
        log_page = LOG_ADDR[LOG_AW-1:PAGE_SHIFT];
    end

    // Common-area-one base register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            common_area_one_base_r <= COMMON_AREA_ONE_BASE_RST;
        end else if (wr_common1) begin
            common_area_one_base_r <= IO_WDATA;
        end
    end

    // Bank base register
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            bank_area_base_r <= BANK_AREA_BASE_RST;
        end else if (wr_bank) begin
            bank_area_base_r <= IO_WDATA;
        end
    end

    // Boundary register; all ones puts pages 0 to 14 in common area 0 and page 15 in common area 1
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            common_one_start_field_r <= COMMON_ONE_START_RST;
            bank_start_field_r <= BANK_START_RST;
        end else if (wr_bounds) begin
            common_one_start_field_r <=
                IO_WDATA[COMMON_ONE_START_LSB+3:COMMON_ONE_START_LSB];
            bank_start_field_r <=
                IO_WDATA[BANK_START_LSB+3:BANK_START_LSB];
        end
    end

    // Read data is registered; unmapped offsets read zero, no hit
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            IO_RDATA <= 8'h00;
        end else if (IO_RD) begin
            case (IO_ADDR)
                COMMON_AREA_ONE_BASE_OFS: IO_RDATA <= common_area_one_base_r;
                BANK_AREA_BASE_OFS: IO_RDATA <= bank_area_base_r;
                AREA_BOUNDARIES_OFS:
                    IO_RDATA <= {common_one_start_field_r, bank_start_field_r};
                default: IO_RDATA <= 8'h00;
            endcase
        end
    end

    // Decode flag, combinational so a host can steer its own read mux
    always_comb begin
        IO_HIT = offset_is(IO_ADDR, COMMON_AREA_ONE_BASE_OFS)
            || offset_is(IO_ADDR, BANK_AREA_BASE_OFS)
            || offset_is(IO_ADDR, AREA_BOUNDARIES_OFS);
    end

    // Translation is combinational; a boundary write acts next cycle
    mmu_xlate u_xlate (
        .log_addr(LOG_ADDR),
        .common_one_base(common_area_one_base_r),
        .bank_base(bank_area_base_r),
        .common_one_start(common_one_start_field_r),
        .bank_start(bank_start_field_r),
        .phy_addr(PHY_ADDR),
        .area(area_sel)
    );

    always_comb begin
        AREA = area_sel;
    end

    // Translation checks; expected sums rebuilt from the registers
    a_common0_pass: assert property (@(posedge CLK)
        disable iff (!RST_N)
        (LOG_ADDR[15:12] < bank_start_field_r
         && LOG_ADDR[15:12] < common_one_start_field_r)
        |-> (PHY_ADDR == {4'h0, LOG_ADDR}))
        else $error("common area 0 not passed through");

    a_common1_sum: assert property (@(posedge CLK)
        disable iff (!RST_N)
        (LOG_ADDR[15:12] >= common_one_start_field_r)
        |-> (PHY_ADDR == 20'({common_area_one_base_r, 12'h000})
             + 20'(LOG_ADDR)))
        else $error("common area 1 address wrong");

    a_bank_sum: assert property (@(posedge CLK)
        disable iff (!RST_N)
        (LOG_ADDR[15:12] >= bank_start_field_r
         && LOG_ADDR[15:12] < common_one_start_field_r)
        |-> (PHY_ADDR == 20'({bank_area_base_r, 12'h000})
             + 20'(LOG_ADDR)))
        else $error("bank area address wrong");

    a_offset_kept: assert property (@(posedge CLK)
        disable iff (!RST_N)
        PHY_ADDR[11:0] == LOG_ADDR[11:0])
        else $error("page offset altered");

    // Area select must agree with the boundary comparison
    a_area_onehot: assert property (@(posedge CLK)
        disable iff (!RST_N)
        $onehot(AREA))
        else $error("area select not one-hot");

    a_area_common0: assert property (@(posedge CLK)
        disable iff (!RST_N)
        (log_page < bank_start_field_r
         && log_page < common_one_start_field_r)
        |-> (AREA == AREA_COMMON0))
        else $error("common area 0 not selected");

    a_area_bank: assert property (@(posedge CLK)
        disable iff (!RST_N)
        (log_page >= bank_start_field_r
         && log_page < common_one_start_field_r)
        |-> (AREA == AREA_BANK))
        else $error("bank area not selected");

    a_area_common1: assert property (@(posedge CLK)
        disable iff (!RST_N)
        (log_page >= common_one_start_field_r)
        |-> (AREA == AREA_COMMON1))
        else $error("common area 1 not selected");

    // Register writes land on the next edge and nowhere else
    a_boundary_write: assert property (@(posedge CLK)
        disable iff (!RST_N)
        (IO_WR && IO_ADDR == AREA_BOUNDARIES_OFS)
        |=> (common_one_start_field_r
             == $past(IO_WDATA[COMMON_ONE_START_LSB+3:COMMON_ONE_START_LSB])
             && bank_start_field_r
             == $past(IO_WDATA[BANK_START_LSB+3:BANK_START_LSB])))
        else $error("boundary write lost");

    a_common1_write: assert property (@(posedge CLK)
        disable iff (!RST_N)
        (IO_WR && IO_ADDR == COMMON_AREA_ONE_BASE_OFS)
        |=> (common_area_one_base_r == $past(IO_WDATA)))
        else $error("common area 1 base write lost");

    a_bank_write: assert property (@(posedge CLK)
        disable iff (!RST_N)
        (IO_WR && IO_ADDR == BANK_AREA_BASE_OFS)
        |=> (bank_area_base_r == $past(IO_WDATA)))
        else $error("bank base write lost");

    a_base_hold: assert property (@(posedge CLK)
        disable iff (!RST_N)
        !(IO_WR && IO_ADDR == BANK_AREA_BASE_OFS)
        |=> $stable(bank_area_base_r))
        else $error("bank base changed without write");

    a_common1_hold: assert property (@(posedge CLK)
        disable iff (!RST_N)
        !(IO_WR && IO_ADDR == COMMON_AREA_ONE_BASE_OFS)
        |=> $stable(common_area_one_base_r))
        else $error("common area 1 base changed without write");

    a_bounds_hold: assert property (@(posedge CLK)
        disable iff (!RST_N)
        !(IO_WR && IO_ADDR == AREA_BOUNDARIES_OFS)
        |=> ($stable(common_one_start_field_r)
             && $stable(bank_start_field_r)))
        else $error("boundaries changed without write");

    // Reads return the value held at the read edge
    a_read_common1: assert property (@(posedge CLK)
        disable iff (!RST_N)
        (IO_RD && IO_ADDR == COMMON_AREA_ONE_BASE_OFS)
        |=> (IO_RDATA == $past(common_area_one_base_r)))
        else $error("common area 1 base read wrong");

    a_read_bank: assert property (@(posedge CLK)
        disable iff (!RST_N)
        (IO_RD && IO_ADDR == BANK_AREA_BASE_OFS)
        |=> (IO_RDATA == $past(bank_area_base_r)))
        else $error("bank base read wrong");

    a_read_bounds: assert property (@(posedge CLK)
        disable iff (!RST_N)
        (IO_RD && IO_ADDR == AREA_BOUNDARIES_OFS)
        |=> (IO_RDATA == {$past(common_one_start_field_r),
                          $past(bank_start_field_r)}))
        else $error("boundary read wrong");

    // Reset values seen at the first edge after release
    a_reset_map: assert property (@(posedge CLK)
        $rose(RST_N) |-> (common_area_one_base_r == COMMON_AREA_ONE_BASE_RST
            && bank_area_base_r == BANK_AREA_BASE_RST
            && common_one_start_field_r == COMMON_ONE_START_RST
            && bank_start_field_r == BANK_START_RST))
        else $error("reset values wrong");

    a_reset_bank: assert property (@(posedge CLK)
        $rose(RST_N) |-> (bank_area_base_r == BANK_AREA_BASE_RST))
        else $error("bank base reset value wrong");

    a_reset_c1_start: assert property (@(posedge CLK)
        $rose(RST_N) |-> (common_one_start_field_r == COMMON_ONE_START_RST))
        else $error("common area 1 start reset value wrong");

    a_reset_bk_start: assert property (@(posedge CLK)
        $rose(RST_N) |-> (bank_start_field_r == BANK_START_RST))
        else $error("bank start reset value wrong");
endmodule // mmu_address_translation

// file: bench/core_model.sv
`timescale 1ns/1ps
// Core side: a new logical address each cycle, just after the edge
module core_model (
    input wire logic CLK,
    input wire logic [15:0] next_addr,
    output logic [15:0] LOG_ADDR
);
    // Launched late so the translator never sees a change at the edge
    initial LOG_ADDR = 16'h0000;
    always @(posedge CLK) LOG_ADDR <= #1 next_addr;
endmodule // core_model

// file: bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    import mmu_pkg::*;
    logic CLK = 0, RST_N = 0, IO_WR = 0, IO_RD = 0, IO_HIT;
    logic [7:0] IO_ADDR = 8'h00, IO_WDATA = 8'h00, IO_RDATA;
    logic [15:0] next_addr = 16'h0000, LOG_ADDR;
    logic [19:0] PHY_ADDR;
    logic [2:0] AREA;
    logic [31:0] seed = 32'h56AF;
    logic [7:0] cb_m = 8'h00, bb_m = 8'h00, bnd_m = 8'hFF;
    int err_count = 0, checked = 0, cycles = 0;
    // Clock and a hang limit well above the some 625 cycles needed
    initial forever #4 CLK = ~CLK;
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            wrap_up();
        end
    end
    core_model CORE (.CLK(CLK), .next_addr(next_addr), .LOG_ADDR(LOG_ADDR));
    mmu_address_translation DUT (.CLK(CLK), .RST_N(RST_N),
        .LOG_ADDR(LOG_ADDR), .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA),
        .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_RDATA(IO_RDATA),
        .IO_HIT(IO_HIT), .PHY_ADDR(PHY_ADDR), .AREA(AREA));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Bus tasks: entered 1 ns after an edge, strobe held over one edge,
    // then an idle edge so a strobe never rises in the step it fell
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        IO_ADDR = a; IO_WDATA = d; IO_WR = 1;
        @(posedge CLK); #1 IO_WR = 0;
        @(posedge CLK); #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        IO_ADDR = a; IO_RD = 1;
        @(posedge CLK); #1 IO_RD = 0;
        `CHK(IO_RDATA, e)
        `CHK(IO_HIT, a inside {8'h38, 8'h39, 8'h3A})
        @(posedge CLK); #1;
    endtask
    // Reference translation from the shadow registers
    task automatic xl(input logic [15:0] a);
        int s;
        logic [2:0] ea;
        next_addr = a;
        @(posedge CLK);
        @(posedge CLK); #1;
        if (a[15:12] >= bnd_m[7:4]) begin
            ea = 3'b100; s = cb_m * 4096;
        end else if (a[15:12] >= bnd_m[3:0]) begin
            ea = 3'b010; s = bb_m * 4096;
        end else begin
            ea = 3'b001; s = 0;
        end
        s = s + a;
        `CHK(PHY_ADDR, s[19:0])
        `CHK(AREA, ea)
    endtask
    task automatic wrap_up();
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence: reset values, random maps, boundary pages, re-reset
    initial begin
        repeat (8) @(posedge CLK);
        #1 RST_N = 1;
        rd(8'h38, 8'h00);
        rd(8'h39, 8'h00);
        rd(8'h3A, 8'hFF);
        xl(16'hF123);
        xl(16'h0ABC);
        for (int i = 0; i < 30; i++) begin
            seed = lfsr(lfsr(lfsr(seed)));
            {bnd_m, bb_m, cb_m} = seed[23:0];
            wr(8'h38, cb_m);
            wr(8'h39, bb_m);
            wr(8'h3A, bnd_m);
            wr(8'h3B, seed[31:24]);
            rd(8'h3B, 8'h00);
            rd(8'h3A, bnd_m);
            xl({bnd_m[7:4], seed[31:20]});
            xl({bnd_m[3:0], 12'h000});
            xl({bnd_m[3:0] - 4'h1, 12'hFFF});
            xl(seed[31:16]);
        end
        RST_N = 0;
        @(posedge CLK); #1 RST_N = 1;
        {bnd_m, bb_m, cb_m} = 24'hFF0000;
        rd(8'h38, 8'h00);
        rd(8'h3A, 8'hFF);
        xl(16'h7FFF);
        wrap_up();
    end
endmodule // tb_top
